// ### hw/hsct_seq.v
// Power-state timing and conversion sequencer for a 3-axis Hall sensor.
// Assumes a separate I2C engine decodes addresses and reads results;
// SCL arrives asynchronously and is synchronised here.
`timescale 1ns/1ps
`include "hsct_consts.vh"

// Overview of operation
// - After power-on reset, reach stand-by within 270 us.
// - From sleep, wake to stand-by within 50 us.
// - Stand-by to continuous measurement takes 70 us first.
// - Fastest averaging: 50 us one channel, plus 25 us per extra axis.
// - Fastest averaging: temperature channel does not change total time.
// - Slowest averaging: 32 samples each, 825 us one, plus 800 us each.
// - Enter sleep 20 us after SCL returns high.
// - Join I2C transactions only in stand-by or continuous measurement.
// - Own address in sleep wakes device without acknowledge.
// - North pole approaching gives positive codes.
// - South pole approaching gives negative codes.
// - Channels converted one after another through one shared ADC.
// - X, Y, Z and temperature results readable over I2C.
// - Read frame format and CRC enable passed to I2C engine.
// - Functional mode follows the power mode select field.
// - Averaging select sets update rate, 000b fastest, 101b slowest.
module hsct_seq #(
  parameter CYC_POWER_UP   = `HSCT_CYC_POWER_UP,
  parameter CYC_WAKE       = `HSCT_CYC_WAKE,
  parameter CYC_START_MEAS = `HSCT_CYC_START_MEAS,
  parameter CYC_SAMPLE     = `HSCT_CYC_SAMPLE,
  parameter CYC_GO_SLEEP   = `HSCT_CYC_GO_SLEEP,
  parameter ADC_W          = 16
) (
  // Clock and reset
  input  wire              i_clk,
  input  wire              i_rstn,
  // Configuration
  input  wire [1:0]        i_power_mode,
  input  wire [2:0]        i_averaging_select,
  input  wire [2:0]        i_axis_enable,
  input  wire              i_temperature_channel_enable,
  input  wire [1:0]        i_read_frame,
  input  wire              i_crc_enable,
  // I2C engine and pin
  input  wire              i_scl,
  input  wire              i_addr_match,
  input  wire              i_bus_done,
  // Shared converter
  input  wire              i_adc_valid,
  input  wire [ADC_W-1:0]  i_adc_data,
  output reg  [1:0]        o_adc_channel,
  output reg               o_adc_start,
  // State and results
  output reg               o_standby,
  output reg               o_measuring,
  output reg               o_asleep,
  output reg               o_i2c_enable,
  output reg               o_addr_ack_enable,
  output reg  [1:0]        o_read_frame,
  output reg               o_crc_enable,
  output reg               o_set_done,
  output reg  [ADC_W-1:0]  o_result_x,
  output reg  [ADC_W-1:0]  o_result_y,
  output reg  [ADC_W-1:0]  o_result_z,
  output reg  [ADC_W-1:0]  o_result_t
);
  localparam ST_POWER_UP = 3'h0;
  localparam ST_STANDBY  = 3'h1;
  localparam ST_START    = 3'h2;
  localparam ST_CONVERT  = 3'h3;
  localparam ST_GO_SLEEP = 3'h4;
  localparam ST_SLEEP    = 3'h5;
  localparam ST_WAKE     = 3'h6;

  reg  [2:0]       state;
  reg  [2:0]       next_state;
  reg  [31:0]      timer;
  reg  [1:0]       chan;
  reg  [5:0]       samples;
  reg              adc_busy;
  reg  [ADC_W+4:0] acc [0:3];
  reg  [31:0]      tail;
  wire             scl_level;
  wire [2:0]       avg_shift;
  wire [ADC_W+4:0] data_ext;
  wire [3:0]       ch_en;
  wire [5:0]       n_samples;
  wire             timer_done;
  wire             chan_last;
  reg  [1:0]       next_chan;

  // SCL passes four flops before use
  hsct_sync hsct_sync_i (
    .i_clk   (i_clk),
    .i_rstn  (i_rstn),
    .i_pin   (i_scl),
    .o_level (scl_level),
    .o_rise  (),
    .o_fall  ()
  );

  // Fast mode drops temperature; set time unchanged, result_t rewritten from the last acc[3] sum, unshifted
  assign ch_en = {i_temperature_channel_enable &
                  (i_averaging_select != `HSCT_AVG_FAST), i_axis_enable};
  // Samples per channel double with each averaging step up to 32 at 101b; 110b and 111b also take 32
  assign n_samples  = (i_averaging_select >= `HSCT_AVG_SLOW) ?
                      6'd32 : (6'd1 << i_averaging_select);
  assign avg_shift  = (i_averaging_select >= `HSCT_AVG_SLOW) ? 3'h5 : i_averaging_select;
  // Sign extension keeps the sensor polarity unchanged
  assign data_ext   = {{5{i_adc_data[ADC_W-1]}}, i_adc_data};
  assign timer_done = (timer == 32'h0);

  // Next enabled channel after the current one, wrapping to the first
  always @* begin
    next_chan = 2'h0;
    if (chan < 2'h1 && ch_en[1])
      next_chan = 2'h1;
    else if (chan < 2'h2 && ch_en[2])
      next_chan = 2'h2;
    else if (chan < 2'h3 && ch_en[3])
      next_chan = 2'h3;
    else if (ch_en[0])
      next_chan = 2'h0;
    else if (ch_en[1])
      next_chan = 2'h1;
    else if (ch_en[2])
      next_chan = 2'h2;
    else
      next_chan = 2'h3;
  end
  assign chan_last = (next_chan <= chan);

  // Power-state sequencing
  always @* begin
    next_state = state;
    case (state)
      ST_POWER_UP: if (timer_done) next_state = ST_STANDBY;
      // Mode field picks the next state
      ST_STANDBY: begin
        if (i_power_mode == `HSCT_MODE_CONT && ch_en != 4'h0)
          next_state = ST_START;
        else if (i_power_mode == `HSCT_MODE_SLEEP ||
                 i_power_mode == `HSCT_MODE_WAKESLEEP)
          next_state = ST_GO_SLEEP;
      end
      ST_START: begin
        if (i_power_mode != `HSCT_MODE_CONT)
          next_state = ST_STANDBY;
        else if (timer_done)
          next_state = ST_CONVERT;
      end
      // Leave only at a set boundary after a mode change
      ST_CONVERT: begin
        if (o_set_done && i_power_mode != `HSCT_MODE_CONT)
          next_state = ST_STANDBY;
      end
      // Sleep after SCL has stood high long enough
      ST_GO_SLEEP: begin
        if (i_power_mode == `HSCT_MODE_STANDBY ||
            i_power_mode == `HSCT_MODE_CONT)
          next_state = ST_STANDBY;
        else if (timer_done)
          next_state = ST_SLEEP;
      end
      // Own address wakes, no acknowledge given
      ST_SLEEP: if (i_addr_match) next_state = ST_WAKE;
      ST_WAKE: if (timer_done) next_state = ST_STANDBY;
      default: next_state = ST_POWER_UP;
    endcase
  end

  // State register and the shared delay timer
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= ST_POWER_UP;
      timer <= CYC_POWER_UP - 1;
    end else begin
      state <= next_state;
      if (next_state != state) begin
        case (next_state)
          ST_START:    timer <= CYC_START_MEAS - 1;
          ST_GO_SLEEP: timer <= CYC_GO_SLEEP - 1;
          ST_WAKE:     timer <= CYC_WAKE - 1;
          default:     timer <= 32'h0;
        endcase
      end else if (state == ST_GO_SLEEP && (!scl_level || i_bus_done)) begin
        // Restart the count while SCL is low or bus active
        timer <= CYC_GO_SLEEP - 1;
      end else if (!timer_done) begin
        timer <= timer - 32'h1;
      end
    end
  end

  // Conversion engine: one channel at a time, results held until set ends
  integer i;
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      chan          <= 2'h0;
      samples       <= 6'h0;
      adc_busy      <= 1'b0;
      o_adc_start   <= 1'b0;
      o_adc_channel <= 2'h0;
      o_set_done    <= 1'b0;
      o_result_x    <= `HSCT_RESULT_RST;
      o_result_y    <= `HSCT_RESULT_RST;
      o_result_z    <= `HSCT_RESULT_RST;
      o_result_t    <= `HSCT_RESULT_RST;
      tail          <= 32'h0;
      for (i = 0; i < 4; i = i + 1)
        acc[i] <= {(ADC_W+5){1'b0}};
    end else begin
      o_adc_start <= 1'b0;
      o_set_done  <= 1'b0;
      if (state != ST_CONVERT) begin
        adc_busy <= 1'b0;
        samples  <= 6'h0;
        tail     <= 32'h0;
        chan     <= ch_en[0] ? 2'h0 : next_chan;
      end else if (tail != 32'h0) begin
        // Closing slot of one sample period ends every set
        tail <= tail - 32'h1;
        if (tail == 32'h1) begin
          o_set_done <= 1'b1;
          // All four results reach the readable outputs at once
          o_result_x <= avg(acc[0]);
          o_result_y <= avg(acc[1]);
          o_result_z <= avg(acc[2]);
          o_result_t <= avg(acc[3]);
        end
      end else if (!adc_busy && !o_set_done) begin
        // One channel on the multiplexer per sample
        o_adc_channel <= chan;
        o_adc_start   <= 1'b1;
        adc_busy      <= 1'b1;
      end else if (adc_busy && i_adc_valid) begin
        adc_busy <= 1'b0;
        // Average by accumulating, then shifting at publication
        acc[chan] <= (samples == 6'h0) ? data_ext : acc[chan] + data_ext;
        if (samples + 6'h1 >= n_samples) begin
          samples <= 6'h0;
          chan    <= next_chan;
          // Last channel opens the closing slot; sums are complete by then
          if (chan_last)
            tail <= CYC_SAMPLE;
        end else begin
          samples <= samples + 6'h1;
        end
      end
    end
  end

  // Arithmetic shift keeps negative codes negative
  function [ADC_W-1:0] avg;
    input [ADC_W+4:0] sum;
    reg   [ADC_W+4:0] quot;
    begin
      quot = $signed(sum) >>> avg_shift;
      avg  = quot[ADC_W-1:0];
    end
  endfunction

  // Status and I2C gating
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_standby         <= 1'b0;
      o_measuring       <= 1'b0;
      o_asleep          <= 1'b0;
      o_i2c_enable      <= 1'b0;
      o_addr_ack_enable <= 1'b0;
      o_read_frame      <= 2'h0;
      o_crc_enable      <= 1'b0;
    end else begin
      // Still stand-by while counting down to sleep
      o_standby    <= (next_state == ST_STANDBY || next_state == ST_GO_SLEEP);
      o_measuring  <= (next_state == ST_START || next_state == ST_CONVERT);
      o_asleep     <= (next_state == ST_SLEEP);
      // Bus only answered in stand-by or measuring
      o_i2c_enable <= (next_state == ST_STANDBY || next_state == ST_START ||
                       next_state == ST_CONVERT || next_state == ST_GO_SLEEP);
      // Never acknowledge while asleep or waking
      o_addr_ack_enable <= (next_state != ST_SLEEP && next_state != ST_WAKE &&
                            next_state != ST_POWER_UP);
      // Frame format and CRC passed to the I2C engine
      o_read_frame <= i_read_frame;
      o_crc_enable <= i_crc_enable;
    end
  end
endmodule // hsct_seq

// ### hw/hsct_consts.vh
// Constants for the Hall sensor conversion sequencer.
// Assumes a 100 MHz core clock; times are in microseconds.
`ifndef HSCT_CONSTS_VH
`define HSCT_CONSTS_VH

`define HSCT_CLK_MHZ        100
`define HSCT_T_POWER_UP_US  270
`define HSCT_T_WAKE_US      50
`define HSCT_T_START_MEAS_US 70
`define HSCT_T_CONV1_US     50
`define HSCT_T_SAMPLE_US    25
`define HSCT_T_GO_SLEEP_US  20
`define HSCT_AVG32_SAMPLES  32
// Cycle counts, each time multiplied by the clock in MHz, all exact
`define HSCT_CYC_POWER_UP   (`HSCT_T_POWER_UP_US * `HSCT_CLK_MHZ)
`define HSCT_CYC_WAKE       (`HSCT_T_WAKE_US * `HSCT_CLK_MHZ)
`define HSCT_CYC_START_MEAS (`HSCT_T_START_MEAS_US * `HSCT_CLK_MHZ)
`define HSCT_CYC_SAMPLE     (`HSCT_T_SAMPLE_US * `HSCT_CLK_MHZ)
`define HSCT_CYC_GO_SLEEP   (`HSCT_T_GO_SLEEP_US * `HSCT_CLK_MHZ)
// Power mode select encodings
`define HSCT_MODE_STANDBY   2'h0
`define HSCT_MODE_WAKESLEEP 2'h1
`define HSCT_MODE_CONT      2'h2
`define HSCT_MODE_SLEEP     2'h3
// Averaging select encodings at the two ends
`define HSCT_AVG_FAST       3'h0
`define HSCT_AVG_SLOW       3'h5
// Channel numbers on the converter multiplexer
`define HSCT_CH_X           2'h0
`define HSCT_CH_Y           2'h1
`define HSCT_CH_Z           2'h2
`define HSCT_CH_T           2'h3
// Reset values
`define HSCT_RESULT_RST     16'h0000

`endif

// ### hw/hsct_sync.v
// Three-stage synchroniser with edge detection for pins.
// Assumes the input is asynchronous to i_clk.
`timescale 1ns/1ps
module hsct_sync (
  // Clock and reset
  input  wire i_clk,
  input  wire i_rstn,
  // Pin in
  input  wire i_pin,
  // Conditioned outputs
  output reg  o_level,
  output wire o_rise,
  output wire o_fall
);
  reg s1;
  reg s2;
  reg s3;

  // First stage is read only by the second
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s1      <= 1'b1;
      s2      <= 1'b1;
      s3      <= 1'b1;
      o_level <= 1'b1;
    end else begin
      s1 <= i_pin;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3)
        o_level <= s3;
    end
  end

  // Change counts only when second and third agree
  assign o_rise = (s2 & s3) & ~o_level;
  assign o_fall = ~(s2 | s3) & o_level;
endmodule // hsct_sync

// ### verif/hsct_seq_checker.sv
// Port checker for the Hall sensor conversion sequencer.
// Assumes one 100 MHz clock domain and the async active-low reset.
`timescale 1ns/1ps
module hsct_seq_checker #(
  parameter int CYC_POWER_UP = 20,
  parameter int CYC_WAKE     = 20,
  parameter int ADC_W        = 16
) (
  // Clock and reset
  input wire             i_clk,
  input wire             i_rstn,
  // Inputs watched
  input wire             i_scl,
  input wire             i_addr_match,
  input wire             i_bus_done,
  input wire [1:0]       i_read_frame,
  input wire             i_crc_enable,
  // Outputs watched
  input wire             o_adc_start,
  input wire             o_standby,
  input wire             o_measuring,
  input wire             o_asleep,
  input wire             o_i2c_enable,
  input wire             o_addr_ack_enable,
  input wire [1:0]       o_read_frame,
  input wire             o_crc_enable,
  input wire             o_set_done,
  input wire [ADC_W-1:0] o_result_x
);
  localparam int PU_MAX = CYC_POWER_UP + 4;
  localparam int WK_MAX = CYC_WAKE + 4;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  power_up_time_a: assert property ($rose(i_rstn) |-> ##[0:PU_MAX] o_standby)
    else $error("stand-by not reached after power-up");
  wake_time_a: assert property ((i_addr_match && o_asleep) |-> ##[1:WK_MAX] o_standby)
    else $error("stand-by not reached after wake");
  sleep_entry_a: assert property ($rose(o_asleep) |->
    $past(i_scl) && $past(i_scl, 16) && !$past(i_bus_done))
    else $error("sleep entered without idle high clock line");
  bus_awake_a: assert property (o_i2c_enable |-> (o_standby || o_measuring))
    else $error("bus enabled outside awake states");
  sleep_no_ack_a: assert property (o_asleep |-> !o_addr_ack_enable && !o_i2c_enable)
    else $error("acknowledge enabled while asleep");
  state_exclusive_a: assert property (!(o_asleep && (o_standby || o_measuring)))
    else $error("asleep and awake at once");
  adc_one_start_a: assert property (o_adc_start |=> !o_adc_start)
    else $error("converter started twice in a row");
  set_done_pulse_a: assert property (o_set_done |=> !o_set_done)
    else $error("set done longer than one cycle");
  result_update_a: assert property ($changed(o_result_x) |-> o_set_done)
    else $error("result changed outside set end");
  frame_copy_a: assert property ($past(i_rstn) |->
    o_read_frame == $past(i_read_frame) && o_crc_enable == $past(i_crc_enable))
    else $error("frame format or check enable not passed on");
endmodule // hsct_seq_checker

bind hsct_seq hsct_seq_checker #(.CYC_POWER_UP(CYC_POWER_UP), .CYC_WAKE(CYC_WAKE), .ADC_W(ADC_W))
  hsct_seq_checker_i (.i_clk(i_clk), .i_rstn(i_rstn), .i_scl(i_scl), .i_addr_match(i_addr_match),
  .i_bus_done(i_bus_done), .i_read_frame(i_read_frame), .i_crc_enable(i_crc_enable),
  .o_adc_start(o_adc_start), .o_standby(o_standby), .o_measuring(o_measuring),
  .o_asleep(o_asleep), .o_i2c_enable(o_i2c_enable), .o_addr_ack_enable(o_addr_ack_enable),
  .o_read_frame(o_read_frame), .o_crc_enable(o_crc_enable), .o_set_done(o_set_done),
  .o_result_x(o_result_x));

// ### verif/hsct_host_model.sv
// Far-side model: bus controller frames and the shared converter.
// Assumes the sequencer pulses a start per sample and waits for valid.
`timescale 1ns/1ps
module hsct_host_model #(
  parameter int CYC_SAMPLE = 20
) (
  // Clock and reset
  input  wire        i_clk,
  input  wire        i_rstn,
  // Converter side
  input  wire        i_adc_start,
  input  wire [1:0]  i_adc_channel,
  output reg         o_adc_valid,
  output reg  [15:0] o_adc_data,
  // Bus side
  output reg         o_scl,
  output reg         o_addr_match,
  output reg         o_bus_done
);
  int       cnt;
  reg [1:0] ch;
  // Field per channel: north on X, south on Y
  function automatic [15:0] code(input [1:0] c);
    case (c)
      2'h0:    code = 16'h0123;
      2'h1:    code = 16'hff00;
      2'h2:    code = 16'h0040;
      default: code = 16'h0200;
    endcase
  endfunction
  // Idle clock line pulled high, no frame at start
  initial begin
    o_scl = 1'b1;
    o_addr_match = 1'b0;
    o_bus_done = 1'b0;
  end
  // Converter answers one sample per start; data toggles while not valid
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt <= 0;
      o_adc_valid <= 1'b0;
      o_adc_data <= 16'h0000;
    end else begin
      o_adc_valid <= 1'b0;
      o_adc_data <= ~o_adc_data;
      if (i_adc_start) begin
        cnt <= CYC_SAMPLE;
        ch <= i_adc_channel;
      end else if (cnt == 1) begin
        cnt <= 0;
        o_adc_valid <= 1'b1;
        o_adc_data <= code(ch);
      end else if (cnt != 0) begin
        cnt <= cnt - 1;
      end
    end
  end
  // One address frame at 160 ns per bit; clock rests high after it
  task automatic send_frame();
    o_bus_done = 1'b1;
    repeat (9) begin
      #80 o_scl = 1'b0;
      #80 o_scl = 1'b1;
    end
    @(posedge i_clk);
    #1 o_addr_match = 1'b1;
    @(posedge i_clk);
    #1 o_addr_match = 1'b0;
    o_bus_done = 1'b0;
  endtask
endmodule // hsct_host_model

// ### verif/hsct_seq_bench.sv
// Self-checking bench for hsct_seq with short timing parameters.
// Assumes the checker is bound in from its own file.
`timescale 1ns/1ps
module hsct_seq_bench;
  localparam int CS = 20;
  reg         clk, rstn, temp, crc;
  reg  [1:0]  mode, frame, ch, frame_o;
  reg  [2:0]  avg, axis;
  wire        scl, hit, busy, vld, start, stb, run, slp, i2c, ack, done, crc_o;
  wire [15:0] data, rx, ry, rz, rt;
  int         errors, num_checks, p1, p2, p3, n, m;

  hsct_seq #(.CYC_POWER_UP(CS), .CYC_WAKE(CS), .CYC_START_MEAS(CS), .CYC_SAMPLE(CS),
    .CYC_GO_SLEEP(CS)) hsct_seq_i (.i_clk(clk), .i_rstn(rstn), .i_power_mode(mode),
    .i_averaging_select(avg), .i_axis_enable(axis), .i_temperature_channel_enable(temp),
    .i_read_frame(frame), .i_crc_enable(crc), .i_scl(scl), .i_addr_match(hit),
    .i_bus_done(busy), .i_adc_valid(vld), .i_adc_data(data), .o_adc_channel(ch),
    .o_adc_start(start), .o_standby(stb), .o_measuring(run), .o_asleep(slp),
    .o_i2c_enable(i2c), .o_addr_ack_enable(ack), .o_read_frame(frame_o), .o_crc_enable(crc_o),
    .o_set_done(done), .o_result_x(rx), .o_result_y(ry), .o_result_z(rz), .o_result_t(rt));
  hsct_host_model #(.CYC_SAMPLE(CS)) hsct_host_model_i (.i_clk(clk), .i_rstn(rstn),
    .i_adc_start(start), .i_adc_channel(ch), .o_adc_valid(vld), .o_adc_data(data),
    .o_scl(scl), .o_addr_match(hit), .o_bus_done(busy));

  task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic rng(string nm, int lo, int hi, int got);
    num_checks++;
    if (got < lo || got > hi) begin
      errors++;
      $display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask
  // Inputs move 1 ns after the edge, outputs read there too
  task automatic step();
    @(posedge clk);
    #1;
  endtask
  task automatic wait_set(output int k);
    step();
    for (k = 1; done !== 1'b1 && k < 5000; k++) step();
  endtask
  task automatic t_power_up();
    rstn = 1'b0;
    repeat (12) step();
    rstn = 1'b1;
    for (n = 0; stb !== 1'b1 && n < 400; n++) step();
    rng("power_up_cycles", CS - 1, CS + 4, n);
    chk("bus_in_standby", 1, i2c);
    frame = frame + 2'h1;
    crc = ~crc;
    step();
    chk("frame_copy", {13'h0, crc, frame}, {13'h0, crc_o, frame_o});
    $display("test power_up done");
  endtask
  task automatic t_fast();
    avg = 3'h0;
    axis = 3'h7;
    temp = 1'b1;
    mode = 2'h2;
    for (n = 0; start !== 1'b1 && n < 400; n++) step();
    rng("start_measure", CS, CS + 4, n);
    wait_set(n);
    wait_set(p3);
    chk("result_x", 16'h0123, rx);
    chk("result_y", 16'hff00, ry);
    chk("result_z", 16'h0040, rz);
    temp = 1'b0;
    wait_set(n);
    wait_set(p2);
    chk("temp_no_effect", p3, p2);
    axis = 3'h1;
    wait_set(n);
    wait_set(p1);
    rng("extra_axes", 2 * CS, 2 * CS + 6, p2 - p1);
    rng("one_channel", 2 * CS, 2 * CS + 6, p1);
    $display("test fast done");
  endtask
  task automatic t_slow();
    avg = 3'h5;
    temp = 1'b1;
    wait_set(n);
    wait_set(p2);
    chk("slow_x", 16'h0123, rx);
    chk("slow_t", 16'h0200, rt);
    temp = 1'b0;
    wait_set(n);
    wait_set(p1);
    rng("extra_channel", 32 * CS, 32 * (CS + 3), p2 - p1);
    rng("slow_rate", 32 * CS, 5000, p1);
    rng("slow_one", 33 * CS, 33 * (CS + 3), p1);
    mode = 2'h0;
    for (n = 0; run !== 1'b0 && n < 5000; n++) step();
    chk("left_continuous", 1, stb);
    $display("test slow done");
  endtask
  task automatic t_sleep();
    for (m = 0; m < 2; m++) begin
      mode = m ? 2'h1 : 2'h3;
      if (m) hsct_host_model_i.send_frame();
      for (n = 0; slp !== 1'b1 && n < 400; n++) step();
      rng("sleep_entry", CS, CS + 8, n);
      chk("ack_asleep", 0, ack);
      chk("bus_asleep", 0, i2c);
      hsct_host_model_i.send_frame();
      mode = 2'h0;
      for (n = 0; stb !== 1'b1 && n < 400; n++) step();
      rng("wake_time", 0, CS + 4, n);
      repeat (CS) step();
      chk("ack_awake", 1, ack);
    end
    $display("test sleep done");
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #300000;
    errors++;
    give_verdict();
  end
  initial begin
    {rstn, temp, crc, mode, frame, avg, axis} = '0;
    t_power_up();
    t_fast();
    t_slow();
    t_sleep();
    t_power_up();
    give_verdict();
  end
endmodule // hsct_seq_bench
